//--- hdl/sensor_monitor_regs.sv
// Purpose: accumulator status and window compare register bank
// Assumes: host port on the system clock, conversions on the same clock
// Notes: read data appear the cycle after the read strobe, zero otherwise
`timescale 1ns/1ps
`default_nettype none
module sensor_monitor_regs
   import sensor_regs_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic gen_call_reset_i,
   input wire logic conv_valid_i,
   input wire logic conv_chan_i,
   input wire logic [11:0] conv_result_i,
   input wire logic chan1_outside_i,
   output logic alert_ch0_o,
   output logic alert_ch1_o,
   output logic summing_on_o,
   output logic irq_o
);
   // configuration registers
   // all of these are plain read-write storage, written whole
   // on a strobe; reserved bits are simply not stored, so they
   // cannot come back as anything but zero
   logic [3:0] sum_en_ff;
   logic [1:0] alert_en_ff;
   logic cmp_en_ff;
   logic [7:0] up_lo_ff;
   logic [3:0] up_hi_ff;
   logic [7:0] lo_lo_ff;
   logic [3:0] lo_hi_ff;
   logic [5:0] hys_ff;
   // status registers
   // count and sum are hardware-owned; host writes to their
   // offsets fall through the decode and are dropped
   // irq status is sticky and only cleared by a host write
   logic [3:0] count_ff;
   logic [15:0] sum_ff;
   logic [2:0] irq_stat_ff;
   logic [2:0] irq_mask_ff;
   // outputs
   logic [7:0] rdata_ff;
   logic alert0_ff;
   logic alert1_ff;
   logic summing_on_ff;
   logic irq_ff;
   // combinational helpers
   // kept separate so each register block stays a single concern
   logic status_clear;
   logic summing_on;
   logic accumulate;
   logic nxt_alert0;
   logic nxt_alert1;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   logic [2:0] nxt_irq_stat;
   logic [7:0] rd_val;

   window_cmp_if ch0_bus ();

   // comparator for channel zero
   // channel one has its own comparator outside this bank; only
   // its outside-window level arrives here, already decided,
   // so just the enable gating is applied to it
   window_cmp u_ch0_cmp (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .cmp (ch0_bus.cmp)
   );

   // limits are the nibble stacked on the low byte
   // the two halves are written independently, so software that
   // moves a limit across a byte boundary sees a brief mixed value;
   // disable the comparator first if that matters
   assign ch0_bus.upper = {up_hi_ff, up_lo_ff};
   assign ch0_bus.lower = {lo_hi_ff, lo_lo_ff};
   assign ch0_bus.hyst = hys_ff;
   assign ch0_bus.enable = cmp_en_ff;
   assign ch0_bus.sample_valid = conv_valid_i && !conv_chan_i;
   assign ch0_bus.sample = conv_result_i;

   // sequence go is a write-only strobe, never stored
   // reading its offset returns zero through the default decode
   // general call reset clears count and sum only; configuration and irq status are kept
   // because a bus-level reset should not lose host settings
   assign status_clear = gen_call_reset_i ||
      (reg_wr_i && (reg_addr_i == ADDR_SEQ_GO) && reg_wdata_i[SEQ_GO_BIT]);

   // reserved codes of the enable field keep the summer idle
   // only the exact all-ones code starts it, so a stray single-bit
   // write can never switch accumulation on by accident
   // both channels advance the count, only channel one adds in
   assign summing_on = (sum_en_ff == SUM_EN_ON);
   assign accumulate = summing_on && conv_valid_i;

   // summing enable field
   // the whole nibble is stored, reserved codes included, so that
   // software reads back exactly what it wrote and can spot a
   // bad code; the decode above keeps the summer idle for them
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sum_en_ff <= RST_NIB;
      end else if (reg_wr_i && (reg_addr_i == ADDR_SUM_EN)) begin
         sum_en_ff <= reg_wdata_i[NIB_W-1:0];
      end
   end

   // per-channel alert enables, off after reset
   // bit 1 gates the external channel one level, bit 0 our
   // own channel zero comparator flags
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         alert_en_ff <= RST_ALERT_EN;
      end else if (reg_wr_i && (reg_addr_i == ADDR_ALERT_EN)) begin
         alert_en_ff <= reg_wdata_i[ALERT_CH1_BIT:ALERT_CH0_BIT];
      end
   end

   // global comparator enable
   // clearing it drops the channel zero flags within one cycle,
   // which also clears any alert that was standing; samples that
   // arrive while it is low are ignored, not queued
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmp_en_ff <= 1'b0;
      end else if (reg_wr_i && (reg_addr_i == ADDR_CMP_EN)) begin
         cmp_en_ff <= reg_wdata_i[CMP_EN_BIT];
      end
   end

   // upper limit low byte
   // takes effect on the next channel zero sample
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         up_lo_ff <= RST_BYTE;
      end else if (reg_wr_i && (reg_addr_i == ADDR_UP_LO)) begin
         up_lo_ff <= reg_wdata_i;
      end
   end

   // upper limit top nibble
   // upper four bits of the write are reserved and dropped
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         up_hi_ff <= RST_NIB;
      end else if (reg_wr_i && (reg_addr_i == ADDR_UP_HI)) begin
         up_hi_ff <= reg_wdata_i[NIB_W-1:0];
      end
   end

   // lower limit low byte
   // takes effect on the next channel zero sample
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lo_lo_ff <= RST_BYTE;
      end else if (reg_wr_i && (reg_addr_i == ADDR_LO_LO)) begin
         lo_lo_ff <= reg_wdata_i;
      end
   end

   // lower limit top nibble
   // upper four bits of the write are reserved and dropped
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lo_hi_ff <= RST_NIB;
      end else if (reg_wr_i && (reg_addr_i == ADDR_LO_HI)) begin
         lo_hi_ff <= reg_wdata_i[NIB_W-1:0];
      end
   end

   // shared hysteresis
   // one band serves both edges of the window; a band wider than
   // the upper limit saturates the release point at zero inside
   // the comparator instead of wrapping round
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hys_ff <= RST_HYS;
      end else if (reg_wr_i && (reg_addr_i == ADDR_HYS)) begin
         hys_ff <= reg_wdata_i[HYS_W-1:0];
      end
   end

   // accumulation count; clear beats a same-cycle conversion so a
   // new sequence always starts from zero
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_ff <= RST_NIB;
      end else if (status_clear) begin
         count_ff <= RST_NIB;
      end else if (accumulate && (count_ff != COUNT_MAX)) begin
         count_ff <= count_ff + 4'h1; // holds at the top, never wraps
      end
   end

   // channel one sum; 16 bits hold sixteen full-scale samples
   // beyond that it wraps silently; the count saturates, so the
   // host can tell from a full count that the sum may have wrapped
   // only the upper byte is visible in this bank
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sum_ff <= RST_SUM;
      end else if (status_clear) begin
         sum_ff <= RST_SUM;
      end else if (accumulate && conv_chan_i) begin
         sum_ff <= sum_ff + {4'h0, conv_result_i};
      end
   end

   // gated alerts: both enables needed
   // registered below, so an alert lags its flag by one cycle;
   // the trade buys a glitch-free pin at the cost of latency
   // and keeps every top-level output on a flip-flop
   assign nxt_alert0 = cmp_en_ff && alert_en_ff[ALERT_CH0_BIT] &&
      (ch0_bus.above || ch0_bus.below);
   assign nxt_alert1 = cmp_en_ff && alert_en_ff[ALERT_CH1_BIT] &&
      chan1_outside_i;

   // alert outputs registered
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         alert0_ff <= 1'b0;
         alert1_ff <= 1'b0;
      end else begin
         alert0_ff <= nxt_alert0;
         alert1_ff <= nxt_alert1;
      end
   end

   // interrupt events only count when the channel may alert
   always_comb begin
      irq_set = RST_IRQ;
      irq_set[IRQ_CH0_ABOVE] = ch0_bus.above_rise && alert_en_ff[ALERT_CH0_BIT];
      irq_set[IRQ_CH0_BELOW] = ch0_bus.below_rise && alert_en_ff[ALERT_CH0_BIT];
      irq_set[IRQ_CH1_ALERT] = nxt_alert1 && !alert1_ff;
      irq_clr = RST_IRQ;
      if (reg_wr_i && (reg_addr_i == ADDR_IRQ_STAT)) begin
         irq_clr = reg_wdata_i[IRQ_W-1:0];
      end
      // set wins over a same-cycle clear so no event is lost
      nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
   end

   // sticky status, write one to clear
   // bits stay set until the host clears them, even after the
   // window returns, so a short excursion is never missed
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_stat_ff <= RST_IRQ;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   // interrupt mask
   // a clear mask bit hides its status bit from the pin but still records it
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_mask_ff <= RST_IRQ;
      end else if (reg_wr_i && (reg_addr_i == ADDR_IRQ_MASK)) begin
         irq_mask_ff <= reg_wdata_i[IRQ_W-1:0];
      end
   end

   // level interrupt, follows status one cycle later
   // stays high until every unmasked status bit is cleared
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // summing state shown on a pin for the converter sequencer
   // one cycle behind the field, like the other status pins
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         summing_on_ff <= 1'b0;
      end else begin
         summing_on_ff <= summing_on;
      end
   end

   // read decode; unmapped and reserved bits read zero
   // the address is decoded in full, so aliases cannot appear
   // reserved bits are padded with zero constants rather than
   // read from storage, which keeps them read-only by construction
   always_comb begin
      rd_val = RST_BYTE;
      case (reg_addr_i)
         ADDR_PROGRESS: rd_val = {4'h0, count_ff};
         ADDR_CH1_SUM_HI: rd_val = sum_ff[SUM_W-1:SUM_W-8];
         ADDR_SUM_EN: rd_val = {4'h0, sum_en_ff};
         ADDR_ALERT_EN: rd_val = {6'h00, alert_en_ff};
         ADDR_CMP_EN: rd_val = {7'h00, cmp_en_ff};
         ADDR_UP_LO: rd_val = up_lo_ff;
         ADDR_UP_HI: rd_val = {4'h0, up_hi_ff};
         ADDR_LO_LO: rd_val = lo_lo_ff;
         ADDR_LO_HI: rd_val = {4'h0, lo_hi_ff};
         ADDR_HYS: rd_val = {2'h0, hys_ff};
         ADDR_IRQ_STAT: rd_val = {5'h00, irq_stat_ff};
         ADDR_IRQ_MASK: rd_val = {5'h00, irq_mask_ff};
         default: rd_val = RST_BYTE;
      endcase
   end

   // read data stand for exactly one cycle after the strobe
   // returning to zero between reads means a host that samples
   // late sees zero rather than stale data, which exposes a
   // timing bug on the host side instead of hiding it
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_ff <= RST_BYTE;
      end else if (reg_rd_i) begin
         rdata_ff <= rd_val;
      end else begin
         rdata_ff <= RST_BYTE;
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign alert_ch0_o = alert0_ff;
   assign alert_ch1_o = alert1_ff;
   assign summing_on_o = summing_on_ff;
   assign irq_o = irq_ff;
endmodule // sensor_monitor_regs
`default_nettype wire

//--- hdl/sensor_regs_pkg.sv
// Purpose: shared constants for the accumulator status and window compare registers
// Assumes: 8-bit register port, byte offsets as listed
// Notes: all offsets, field positions, reset values and widths live here
package sensor_regs_pkg;
   // register offsets
   localparam logic [7:0] ADDR_PROGRESS = 8'h02;
   localparam logic [7:0] ADDR_CH1_SUM_HI = 8'h0b;
   localparam logic [7:0] ADDR_SEQ_GO = 8'h1f;
   localparam logic [7:0] ADDR_SUM_EN = 8'h30;
   localparam logic [7:0] ADDR_ALERT_EN = 8'h34;
   localparam logic [7:0] ADDR_CMP_EN = 8'h37;
   localparam logic [7:0] ADDR_UP_LO = 8'h38;
   localparam logic [7:0] ADDR_UP_HI = 8'h39;
   localparam logic [7:0] ADDR_LO_LO = 8'h3a;
   localparam logic [7:0] ADDR_LO_HI = 8'h3b;
   localparam logic [7:0] ADDR_HYS = 8'h40;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h50;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h51;
   // field widths
   localparam int COUNT_W = 4;
   localparam int SUM_W = 16;
   localparam int THR_W = 12;
   localparam int NIB_W = 4;
   localparam int HYS_W = 6;
   localparam int IRQ_W = 3;
   // field positions
   localparam int SEQ_GO_BIT = 0;
   localparam int CMP_EN_BIT = 0;
   localparam int ALERT_CH0_BIT = 0;
   localparam int ALERT_CH1_BIT = 1;
   localparam int IRQ_CH0_ABOVE = 0;
   localparam int IRQ_CH0_BELOW = 1;
   localparam int IRQ_CH1_ALERT = 2;
   // codes and reset values
   localparam logic [3:0] SUM_EN_ON = 4'hf;
   localparam logic [3:0] COUNT_MAX = 4'hf;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_NIB = 4'h0;
   localparam logic [5:0] RST_HYS = 6'h00;
   localparam logic [1:0] RST_ALERT_EN = 2'h0;
   localparam logic [2:0] RST_IRQ = 3'h0;
   localparam logic [15:0] RST_SUM = 16'h0000;
endpackage

//--- hdl/window_cmp.sv
// Purpose: one channel window comparator with shared hysteresis
// Assumes: a sample is a 12-bit result with a one-cycle valid
// Notes: flags drop to zero while the block is disabled
`timescale 1ns/1ps
`default_nettype none
module window_cmp
   import sensor_regs_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   window_cmp_if.cmp cmp
);
   logic [12:0] up_release;
   logic [12:0] lo_release;
   logic above_ff;
   logic below_ff;
   logic above_rise_ff;
   logic below_rise_ff;

   // release points, upper saturated at zero and lower one bit wider, so a big hysteresis cannot wrap
   always_comb begin
      up_release = {1'b0, cmp.upper} - {7'h00, cmp.hyst};
      if ({1'b0, cmp.upper} < {7'h00, cmp.hyst}) begin
         up_release = 13'h0000;
      end
      lo_release = {1'b0, cmp.lower} + {7'h00, cmp.hyst};
   end

   // above-window flag, one hysteresis value for both sides
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         above_ff <= 1'b0;
         above_rise_ff <= 1'b0;
      end else if (!cmp.enable) begin
         above_ff <= 1'b0;
         above_rise_ff <= 1'b0;
      end else if (cmp.sample_valid) begin
         above_rise_ff <= !above_ff && (cmp.sample > cmp.upper);
         if (cmp.sample > cmp.upper) begin
            above_ff <= 1'b1;
         end else if ({1'b0, cmp.sample} < up_release) begin
            above_ff <= 1'b0;
         end
      end else begin
         above_rise_ff <= 1'b0;
      end
   end

   // below-window flag
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         below_ff <= 1'b0;
         below_rise_ff <= 1'b0;
      end else if (!cmp.enable) begin
         below_ff <= 1'b0;
         below_rise_ff <= 1'b0;
      end else if (cmp.sample_valid) begin
         below_rise_ff <= !below_ff && (cmp.sample < cmp.lower);
         if (cmp.sample < cmp.lower) begin
            below_ff <= 1'b1;
         end else if ({1'b0, cmp.sample} > lo_release) begin
            below_ff <= 1'b0;
         end
      end else begin
         below_rise_ff <= 1'b0;
      end
   end

   assign cmp.above = above_ff;
   assign cmp.below = below_ff;
   assign cmp.above_rise = above_rise_ff;
   assign cmp.below_rise = below_rise_ff;
endmodule // window_cmp
`default_nettype wire

//--- hdl/window_cmp_if.sv
// Purpose: carries one channel's limits, samples and compare results
// Assumes: single clock, driven by the register bank and the comparator
// Notes: no clocking block, plain nets only
`timescale 1ns/1ps
`default_nettype none
interface window_cmp_if;
   logic [11:0] upper;
   logic [11:0] lower;
   logic [5:0] hyst;
   logic enable;
   logic sample_valid;
   logic [11:0] sample;
   logic above;
   logic below;
   logic above_rise;
   logic below_rise;
   // register bank side
   modport cfg (output upper, lower, hyst, enable, sample_valid, sample,
      input above, below, above_rise, below_rise);
   // comparator side
   modport cmp (input upper, lower, hyst, enable, sample_valid, sample,
      output above, below, above_rise, below_rise);
endinterface
`default_nettype wire

//--- verification/accum_status_window_compare_regs_test.sv
// Purpose: self-checking bench for the register bank
// Assumes: host model issues all register traffic
// Notes: waits after a conversion cover the two-cycle alert path and the three-cycle irq path
`timescale 1ns/1ps
`default_nettype none
module accum_status_window_compare_regs_test
   import sensor_regs_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, al0, al1, son, irq;
   logic gcr = 1'b0;
   logic cv = 1'b0;
   logic cch = 1'b0;
   logic out1 = 1'b0;
   logic [11:0] cres = 12'h000;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [7:0] ra [11] = '{8'h34, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h40, 8'h30, 8'h02,
      8'h0b, 8'h7e};
   logic [7:0] rm [11] = '{8'h03, 8'h01, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h3f, 8'h0f, 8'h00,
      8'h00, 8'h00};
   host_cpu_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
   sensor_monitor_regs dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .gen_call_reset_i(gcr), .conv_valid_i(cv), .conv_chan_i(cch), .conv_result_i(cres),
      .chan1_outside_i(out1), .alert_ch0_o(al0), .alert_ch1_o(al1), .summing_on_o(son),
      .irq_o(irq));
   // 250 MHz system clock
   initial begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic bchk(input string w, input logic e, input logic g);
      chk(w, {7'h00, e}, {7'h00, g});
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   // one conversion pulse, then room for flags, alert and irq to land
   task automatic conv(input logic ch, input logic [11:0] r);
      @(posedge clk_sys_i);
      cv <= 1'b1;
      cch <= ch;
      cres <= r;
      @(posedge clk_sys_i);
      cv <= 1'b0;
      cres <= ~r;
      repeat (3) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic t_reset_values();
      foreach (ra[i]) rchk(ra[i], 8'h00);
   endtask
   // two patterns catch stuck-at-zero on every bit, stuck-at-one on bits 0, 2, 5 and 7 only; reserved bits masked off
   task automatic t_rw_fields();
      logic [7:0] p;
      for (int k = 0; k < 2; k++) begin
         p = k ? 8'h5a : 8'hff;
         foreach (ra[i]) begin
            host.wr(ra[i], p);
            rchk(ra[i], p & rm[i]);
            if (ra[i] == ADDR_SUM_EN) bchk("summing", k == 0, son);
            host.wr(ra[i], 8'h00);
         end
      end
   endtask
   task automatic t_accumulate();
      host.wr(ADDR_SUM_EN, 8'h0f);
      conv(1'b1, 12'h800);
      conv(1'b1, 12'hfff);
      conv(1'b0, 12'h123);
      rchk(ADDR_CH1_SUM_HI, 8'h17);
      rchk(ADDR_PROGRESS, 8'h03);
      host.wr(ADDR_SEQ_GO, 8'h01);
      rchk(ADDR_CH1_SUM_HI, 8'h00);
      rchk(ADDR_PROGRESS, 8'h00);
      repeat (17) conv(1'b1, 12'h010);
      rchk(ADDR_PROGRESS, 8'h0f);
      rchk(ADDR_CH1_SUM_HI, 8'h01);
      @(posedge clk_sys_i);
      gcr <= 1'b1;
      @(posedge clk_sys_i);
      gcr <= 1'b0;
      rchk(ADDR_PROGRESS, 8'h00);
      host.wr(ADDR_SUM_EN, 8'h07);
      conv(1'b1, 12'hfff);
      rchk(ADDR_CH1_SUM_HI, 8'h00);
      rchk(ADDR_PROGRESS, 8'h00);
   endtask
   // limits 0x100 and 0x080 with a 0x10 band
   task automatic t_window();
      host.wr(ADDR_UP_HI, 8'h01);
      host.wr(ADDR_UP_LO, 8'h00);
      host.wr(ADDR_LO_LO, 8'h80);
      host.wr(ADDR_HYS, 8'h10);
      host.wr(ADDR_IRQ_MASK, 8'h07);
      host.wr(ADDR_ALERT_EN, 8'h01);
      conv(1'b0, 12'h200);
      bchk("alert0", 1'b0, al0);
      host.wr(ADDR_CMP_EN, 8'h01);
      conv(1'b0, 12'h100);
      bchk("alert0", 1'b0, al0);
      conv(1'b0, 12'h101);
      bchk("alert0", 1'b1, al0);
      bchk("irq", 1'b1, irq);
      conv(1'b0, 12'h0f5);
      bchk("alert0", 1'b1, al0);
      conv(1'b0, 12'h0ef);
      bchk("alert0", 1'b0, al0);
      conv(1'b0, 12'h07f);
      bchk("alert0", 1'b1, al0);
      rchk(ADDR_IRQ_STAT, 8'h03);
      host.wr(ADDR_IRQ_STAT, 8'h03);
      host.wr(ADDR_IRQ_MASK, 8'h00);
      conv(1'b0, 12'h100);
      conv(1'b0, 12'h07f);
      bchk("irq", 1'b0, irq);
      host.wr(ADDR_IRQ_MASK, 8'h02);
      rchk(ADDR_IRQ_STAT, 8'h02);
      bchk("irq", 1'b1, irq);
      host.wr(ADDR_ALERT_EN, 8'h00);
      rchk(ADDR_ALERT_EN, 8'h00);
      bchk("alert0", 1'b0, al0);
      @(posedge clk_sys_i);
      out1 <= 1'b1;
      host.wr(ADDR_ALERT_EN, 8'h01);
      rchk(ADDR_ALERT_EN, 8'h01);
      bchk("alert1", 1'b0, al1);
      host.wr(ADDR_ALERT_EN, 8'h02);
      rchk(ADDR_ALERT_EN, 8'h02);
      bchk("alert1", 1'b1, al1);
      host.wr(ADDR_CMP_EN, 8'h00);
      rchk(ADDR_CMP_EN, 8'h00);
      bchk("alert1", 1'b0, al1);
      out1 <= 1'b0;
   endtask
   task automatic t_mid_reset();
      host.wr(ADDR_SUM_EN, 8'h0f);
      conv(1'b1, 12'hfff);
      host.wr(ADDR_UP_LO, 8'h5a);
      @(posedge clk_sys_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      rchk(ADDR_CH1_SUM_HI, 8'h00);
      rchk(ADDR_UP_LO, 8'h00);
      rchk(ADDR_ALERT_EN, 8'h00);
   endtask
   // reset for 8 cycles, then the scenarios in turn
   initial begin
      repeat (8) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      t_reset_values();
      t_rw_fields();
      t_accumulate();
      t_window();
      t_mid_reset();
      end_of_test();
   end
endmodule // accum_status_window_compare_regs_test
`default_nettype wire

//--- verification/host_cpu_model.sv
// Purpose: host software model driving the register port
// Assumes: strobes launched right after a rising edge, read data one cycle later
// Notes: a released address or data bus is inverted so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
   input wire logic clk_sys_i,
   input wire logic [7:0] reg_rdata_i,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o
);
   // bus idle at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   // one-cycle write strobe, then scramble the released bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      d = reg_rdata_i;
   endtask
endmodule // host_cpu_model
`default_nettype wire

//--- verification/sensor_monitor_regs_assertions.sv
// Purpose: port-level assertions on the register bank
// Assumes: one clock, asynchronous active-low reset
// Notes: shadows a few host writes rather than peeking inside the bank
`timescale 1ns/1ps
`default_nettype none
module sensor_monitor_regs_checker
   import sensor_regs_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic gen_call_reset_i,
   input wire logic conv_valid_i,
   input wire logic conv_chan_i,
   input wire logic [11:0] conv_result_i,
   input wire logic chan1_outside_i,
   input wire logic alert_ch0_o,
   input wire logic alert_ch1_o,
   input wire logic summing_on_o,
   input wire logic irq_o
);
   logic [2:0] en_ff; // block enable, ch1 enable, ch0 enable
   logic [7:0] up_lo_ff;
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);
   // enable shadow, updated on the same edge as the bank
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         en_ff <= 3'h0;
      end else if (reg_wr_i && reg_addr_i == ADDR_CMP_EN) begin
         en_ff[2] <= reg_wdata_i[CMP_EN_BIT];
      end else if (reg_wr_i && reg_addr_i == ADDR_ALERT_EN) begin
         en_ff[1:0] <= reg_wdata_i[1:0];
      end
   end
   // limit byte shadow
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         up_lo_ff <= 8'h00;
      end else if (reg_wr_i && reg_addr_i == ADDR_UP_LO) begin
         up_lo_ff <= reg_wdata_i;
      end
   end
   a_rdata_quiet_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data not zero outside a read answer");
   a_progress_top_zero: assert property (
      $past(reg_rd_i && reg_addr_i == ADDR_PROGRESS) |-> reg_rdata_o[7:4] == 4'h0)
      else $error("progress upper bits not zero");
   a_cmp_en_top_zero: assert property (
      $past(reg_rd_i && reg_addr_i == ADDR_CMP_EN) |-> reg_rdata_o[7:1] == 7'h00)
      else $error("block enable upper bits not zero");
   a_hyst_top_zero: assert property (
      $past(reg_rd_i && reg_addr_i == ADDR_HYS) |-> reg_rdata_o[7:6] == 2'h0)
      else $error("hysteresis upper bits not zero");
   a_limit_byte_back: assert property (
      $past(reg_rd_i && reg_addr_i == ADDR_UP_LO) |-> reg_rdata_o == $past(up_lo_ff))
      else $error("upper limit byte read back wrong");
   a_alert0_gated: assert property (alert_ch0_o |-> $past(en_ff[2] && en_ff[0]))
      else $error("channel zero alert without enables");
   a_alert1_follows: assert property (
      alert_ch1_o == $past(en_ff[2] && en_ff[1] && chan1_outside_i))
      else $error("channel one alert not gated level");
   a_summing_follows: assert property (
      $past(reg_wr_i && reg_addr_i == ADDR_SUM_EN)
      |-> ##1 summing_on_o == ($past(reg_wdata_i[3:0], 2) == SUM_EN_ON))
      else $error("summing flag does not follow field");
endmodule // sensor_monitor_regs_checker
bind sensor_monitor_regs sensor_monitor_regs_checker checker_i (
   .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .gen_call_reset_i(gen_call_reset_i),
   .conv_valid_i(conv_valid_i), .conv_chan_i(conv_chan_i), .conv_result_i(conv_result_i),
   .chan1_outside_i(chan1_outside_i), .alert_ch0_o(alert_ch0_o),
   .alert_ch1_o(alert_ch1_o), .summing_on_o(summing_on_o), .irq_o(irq_o));
`default_nettype wire
